//--- dv/test_led_driver_config_regs.sv
/*
  Self-checking testbench of the LED driver configuration register slice.
  Assumes the strobe register port and one load cycle after each reset.
*/
`timescale 1ns/1ps
module test_led_driver_config_regs;
  logic core_clk, nrst, reg_wr, reg_rd, reg_rvalid, volt_st, exp_st;
  logic [7:0] reg_addr, reg_wdata, reg_rdata, diag_lo;
  logic [11:0] diag_st;
  logic [3:0] freq_st, diag_hi, freq_code;
  logic [1:0] ratio_st, ratio_code;
  logic cfg_ready, auto_on, volt_sel, exp_on;
  ldcr_pkg::ldcr_freq_t pwm_freq_dhz;
  ldcr_pkg::ldcr_ratio_t ref_ratio;
  int err_count = 0;
  int total_checks = 0;
  // Reserved bits must come back as zero after an all-ones write
  logic [7:0] ones_exp [4] = '{8'hFF, 8'h0F, 8'hD0, 8'hF3};
  logic [17:0] freq_tab [16] = '{18'h007D0, 18'h009C4, 18'h00BB8, 18'h00DAC,
    18'h00FA0, 18'h01388, 18'h01770, 18'h01F40, 18'h02710, 18'h02EE0,
    18'h04E20, 18'h09C40, 18'h0E678, 18'h130B0, 18'h17700, 18'h32C80};

  ldcr_regs i_ldcr_regs (
    .i_core_clk(core_clk),
    .i_nrst(nrst),
    .i_reg_addr(reg_addr),
    .i_reg_wr(reg_wr),
    .i_reg_wdata(reg_wdata),
    .i_reg_rd(reg_rd),
    .o_reg_rdata(reg_rdata),
    .o_reg_rvalid(reg_rvalid),
    .i_chan_diag_on_stored(diag_st),
    .i_regulator_voltage_select_stored(volt_st),
    .i_exponential_dimming_on_stored(exp_st),
    .i_pulse_frequency_code_stored(freq_st),
    .i_reference_ratio_code_stored(ratio_st),
    .o_cfg_ready(cfg_ready),
    .o_diag_enable_lo_channels(diag_lo),
    .o_diag_enable_hi_channels(diag_hi),
    .o_auto_single_short_check_on(auto_on),
    .o_regulator_voltage_select(volt_sel),
    .o_exponential_dimming_on(exp_on),
    .o_pulse_frequency_code(freq_code),
    .o_reference_ratio_code(ratio_code),
    .o_pwm_freq_dhz(pwm_freq_dhz),
    .o_ref_ratio(ref_ratio)
  );

  initial begin
    core_clk = 1'b0;
    forever #5 core_clk = ~core_clk;
  end

  task automatic chk(input string what, input logic [17:0] exp, input logic [17:0] got);
    total_checks++;
    if (got !== exp) begin
      err_count++;
      $display("FAIL %s expected %0h seen %0h", what, exp, got);
    end
  endtask

  // Strobe drops one edge later, so calls never share an edge
  task automatic wr_reg(input logic [7:0] a, input logic [7:0] d);
    @(posedge core_clk);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge core_clk);
    reg_wr <= 1'b0;
    #1;
  endtask

  task automatic rd_chk(input logic [7:0] a, input logic [7:0] exp);
    @(posedge core_clk);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge core_clk);
    reg_rd <= 1'b0;
    #1;
    chk("read valid", 18'h00001, {17'h00000, reg_rvalid});
    chk("read data", {10'h000, exp}, {10'h000, reg_rdata});
    @(posedge core_clk);
    #1;
    chk("read valid drop", 18'h00000, {17'h00000, reg_rvalid});
  endtask

  task automatic results;
    $display("checks %0d mismatches %0d", total_checks, err_count);
    if (err_count == 0 && total_checks > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask

  initial begin
    repeat (3000) @(posedge core_clk);
    err_count++;
    results();
  end

  initial begin
    nrst = 1'b0;
    reg_addr = 8'h00;
    reg_wdata = 8'h00;
    reg_wr = 1'b0;
    reg_rd = 1'b0;
    diag_st = 12'hA5C;
    volt_st = 1'b1;
    exp_st = 1'b1;
    freq_st = 4'hC;
    ratio_st = 2'h2;
    repeat (11) @(posedge core_clk);
    #1;
    chk("reset ratio", 18'h00040, {8'h00, ref_ratio});
    chk("reset freq", 18'h007D0, pwm_freq_dhz);
    chk("reset ready", 18'h00000, {17'h00000, cfg_ready});
    @(posedge core_clk);
    nrst <= 1'b1;
    repeat (3) @(posedge core_clk);
    #1;
    chk("ready", 18'h00001, {17'h00000, cfg_ready});
    chk("diag lo", 18'h0005C, {10'h000, diag_lo});
    chk("diag hi", 18'h0000A, {14'h0000, diag_hi});
    chk("auto", 18'h00000, {17'h00000, auto_on});
    chk("volt", 18'h00001, {17'h00000, volt_sel});
    chk("exp", 18'h00001, {17'h00000, exp_on});
    chk("freq", 18'h0E678, pwm_freq_dhz);
    chk("ratio", 18'h00100, {8'h00, ref_ratio});
    rd_chk(8'h54, 8'h5C);
    rd_chk(8'h55, 8'h0A);
    rd_chk(8'h56, 8'h50);
    rd_chk(8'h57, 8'hC2);
    for (int i = 0; i < 4; i++) begin
      wr_reg(8'h54 + i[7:0], 8'hFF);
      rd_chk(8'h54 + i[7:0], ones_exp[i]);
      wr_reg(8'h54 + i[7:0], 8'h00);
      rd_chk(8'h54 + i[7:0], 8'h00);
    end
    wr_reg(8'h54, 8'hA5);
    chk("diag lo", 18'h000A5, {10'h000, diag_lo});
    wr_reg(8'h55, 8'h96);
    chk("diag hi", 18'h00006, {14'h0000, diag_hi});
    wr_reg(8'h56, 8'h80);
    chk("auto", 18'h00001, {17'h00000, auto_on});
    chk("volt", 18'h00000, {17'h00000, volt_sel});
    chk("exp", 18'h00000, {17'h00000, exp_on});
    wr_reg(8'h56, 8'h5F);
    rd_chk(8'h56, 8'h50);
    chk("exp", 18'h00001, {17'h00000, exp_on});
    for (int c = 0; c < 16; c++) begin
      wr_reg(8'h57, {c[3:0], 2'h3, c[1:0]});
      @(posedge core_clk);
      #1;
      chk("freq code", {14'h0000, c[3:0]}, {14'h0000, freq_code});
      chk("ratio code", {16'h0000, c[1:0]}, {16'h0000, ratio_code});
      chk("freq", freq_tab[c], pwm_freq_dhz);
      chk("ratio", 18'h00040 << c[1:0], {8'h00, ref_ratio});
    end
    // Unmapped places take nothing and read as zero
    wr_reg(8'h58, 8'hFF);
    rd_chk(8'h58, 8'h00);
    rd_chk(8'h53, 8'h00);
    rd_chk(8'h57, 8'hF3);
    wr_reg(8'h56, 8'hD0);
    // Second reset; a write held across the load edge must lose
    @(posedge core_clk);
    nrst <= 1'b0;
    diag_st <= 12'h3C1;
    volt_st <= 1'b0;
    exp_st <= 1'b0;
    freq_st <= 4'h0;
    ratio_st <= 2'h0;
    reg_addr <= 8'h54;
    reg_wdata <= 8'hFF;
    reg_wr <= 1'b1;
    repeat (2) @(posedge core_clk);
    nrst <= 1'b1;
    @(posedge core_clk);
    reg_wr <= 1'b0;
    repeat (2) @(posedge core_clk);
    #1;
    chk("diag lo", 18'h000C1, {10'h000, diag_lo});
    chk("diag hi", 18'h00003, {14'h0000, diag_hi});
    chk("auto", 18'h00000, {17'h00000, auto_on});
    chk("volt", 18'h00000, {17'h00000, volt_sel});
    chk("exp", 18'h00000, {17'h00000, exp_on});
    chk("freq", 18'h007D0, pwm_freq_dhz);
    rd_chk(8'h57, 8'h00);
    results();
  end
endmodule // test_led_driver_config_regs

//--- hdl/ldcr_consts.svh
/*
  Offsets, field positions, reset values and decode tables of the LED
  driver configuration register slice.
  Assumes an 8-bit register address and 8-bit register data.
*/
`ifndef LDCR_CONSTS_SVH
`define LDCR_CONSTS_SVH

// Register offsets
`define LDCR_OFF_DIAG_LO 8'h54
`define LDCR_OFF_DIAG_HI 8'h55
`define LDCR_OFF_MISC_A 8'h56
`define LDCR_OFF_MISC_B 8'h57

// Field positions
`define LDCR_DIAG_HI_W 4
`define LDCR_POS_AUTO_SHORT 7
`define LDCR_POS_VOLT_SEL 6
`define LDCR_POS_EXP_DIM 4
`define LDCR_POS_FREQ_LSB 4
`define LDCR_POS_RATIO_LSB 0

// Reset values
`define LDCR_RST_BYTE 8'h00
`define LDCR_RST_AUTO_SHORT 1'h0

// Pulse frequency per code, in units of 0.1 Hz
`define LDCR_FREQ_0 18'h007D0
`define LDCR_FREQ_1 18'h009C4
`define LDCR_FREQ_2 18'h00BB8
`define LDCR_FREQ_3 18'h00DAC
`define LDCR_FREQ_4 18'h00FA0
`define LDCR_FREQ_5 18'h01388
`define LDCR_FREQ_6 18'h01770
`define LDCR_FREQ_7 18'h01F40
`define LDCR_FREQ_8 18'h02710
`define LDCR_FREQ_9 18'h02EE0
`define LDCR_FREQ_A 18'h04E20
`define LDCR_FREQ_B 18'h09C40
`define LDCR_FREQ_C 18'h0E678
`define LDCR_FREQ_D 18'h130B0
`define LDCR_FREQ_E 18'h17700
`define LDCR_FREQ_F 18'h32C80

// Smallest reference current ratio; each code step doubles it
`define LDCR_RATIO_BASE 10'h040

`endif

//--- hdl/ldcr_field.sv
/*
  One configuration field: loaded from its stored copy, written by software.
  Assumes load and write come from logic on the same clock.
*/
`timescale 1ns/1ps
module ldcr_field #(
  parameter int W = 1,
  parameter logic [W-1:0] RST = '0
) (
  // Clock and reset
  input wire logic i_core_clk,
  input wire logic i_nrst,
  // Load from stored copy
  input wire logic i_load,
  input wire logic [W-1:0] i_load_val,
  // Software write
  input wire logic i_wr,
  input wire logic [W-1:0] i_wr_val,
  // Field value
  output logic [W-1:0] o_q
);

  // Load wins, so the stored copy is never half overwritten
  always_ff @(posedge i_core_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      o_q <= RST;
    end else if (i_load) begin
      o_q <= i_load_val;
    end else if (i_wr) begin
      o_q <= i_wr_val;
    end
  end

endmodule // ldcr_field

//--- hdl/ldcr_pkg.sv
/*
  Types of the LED driver configuration register slice.
  Assumes nothing of its surroundings.
*/
package ldcr_pkg;

  typedef enum logic {
    LDCR_LOAD,
    LDCR_RUN
  } ldcr_state_e;

  typedef logic [17:0] ldcr_freq_t;
  typedef logic [9:0] ldcr_ratio_t;

endpackage

//--- hdl/ldcr_regs.sv
/*
  Configuration register slice of a 12-channel LED driver: diagnostics
  enables and two miscellaneous configuration registers, with decode.
  Assumes the register port and the stored copies are on i_core_clk.
*/
`timescale 1ns/1ps
`include "ldcr_consts.svh"

// What this block does
// - Read/write diagnostics enable per channel 0-7, bit n for channel n.
// - Channels 8-11 enables in bits 3-0; bits 7-4 reserved read zero.
// - After reset each diagnostics enable loads from its stored copy.
// - Auto single-LED short check enable at bit 7, resets to zero.
// - Regulator voltage select at bit 6: 0 is 5.0V, 1 is 4.4V.
// - Exponential dimming enable at bit 4; 1 enables the curve.
// - Voltage select and dimming enable load from stored copies; bit 5 zero.
// - Decode 4-bit pulse frequency code, 200 Hz up to 20.8 kHz.
// - Decode 2-bit reference ratio code to 64, 128, 256 or 512.
// - Frequency and ratio codes load from stored copies; gap bits read zero.
module ldcr_regs
  import ldcr_pkg::*;
(
  // Clock and reset
  input wire logic i_core_clk,
  input wire logic i_nrst,
  // Register port
  input wire logic [7:0] i_reg_addr,
  input wire logic i_reg_wr,
  input wire logic [7:0] i_reg_wdata,
  input wire logic i_reg_rd,
  output logic [7:0] o_reg_rdata,
  output logic o_reg_rvalid,
  // Stored copies
  input wire logic [11:0] i_chan_diag_on_stored,
  input wire logic i_regulator_voltage_select_stored,
  input wire logic i_exponential_dimming_on_stored,
  input wire logic [3:0] i_pulse_frequency_code_stored,
  input wire logic [1:0] i_reference_ratio_code_stored,
  // Configuration outputs
  output logic o_cfg_ready,
  output logic [7:0] o_diag_enable_lo_channels,
  output logic [3:0] o_diag_enable_hi_channels,
  output logic o_auto_single_short_check_on,
  output logic o_regulator_voltage_select,
  output logic o_exponential_dimming_on,
  output logic [3:0] o_pulse_frequency_code,
  output logic [1:0] o_reference_ratio_code,
  output ldcr_freq_t o_pwm_freq_dhz,
  output ldcr_ratio_t o_ref_ratio
);

  ldcr_state_e state;
  logic load;
  logic wr_run;
  logic wr_lo;
  logic wr_hi;
  logic wr_a;
  logic wr_b;
  logic [7:0] next_rdata;
  ldcr_freq_t next_freq;

  // One load cycle after release; stored copies are settled by then
  always_ff @(posedge i_core_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      state <= LDCR_LOAD;
    end else begin
      case (state)
        LDCR_LOAD: state <= LDCR_RUN;
        LDCR_RUN: state <= LDCR_RUN;
        default: state <= LDCR_LOAD;
      endcase
    end
  end

  assign load = (state == LDCR_LOAD);
  assign wr_run = i_reg_wr && !load;
  assign wr_lo = wr_run && (i_reg_addr == `LDCR_OFF_DIAG_LO);
  assign wr_hi = wr_run && (i_reg_addr == `LDCR_OFF_DIAG_HI);
  assign wr_a = wr_run && (i_reg_addr == `LDCR_OFF_MISC_A);
  assign wr_b = wr_run && (i_reg_addr == `LDCR_OFF_MISC_B);

  always_ff @(posedge i_core_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      o_cfg_ready <= 1'b0;
    end else begin
      o_cfg_ready <= !load;
    end
  end

  ldcr_field #(.W(8)) u_diag_lo (
    .i_core_clk(i_core_clk),
    .i_nrst(i_nrst),
    .i_load(load),
    .i_load_val(i_chan_diag_on_stored[7:0]),
    .i_wr(wr_lo),
    .i_wr_val(i_reg_wdata),
    .o_q(o_diag_enable_lo_channels)
  );

  ldcr_field #(.W(`LDCR_DIAG_HI_W)) u_diag_hi (
    .i_core_clk(i_core_clk),
    .i_nrst(i_nrst),
    .i_load(load),
    .i_load_val(i_chan_diag_on_stored[11:8]),
    .i_wr(wr_hi),
    .i_wr_val(i_reg_wdata[`LDCR_DIAG_HI_W-1:0]),
    .o_q(o_diag_enable_hi_channels)
  );

  // No stored copy: the load puts back the reset value
  ldcr_field #(.W(1), .RST(`LDCR_RST_AUTO_SHORT)) u_auto (
    .i_core_clk(i_core_clk),
    .i_nrst(i_nrst),
    .i_load(load),
    .i_load_val(`LDCR_RST_AUTO_SHORT),
    .i_wr(wr_a),
    .i_wr_val(i_reg_wdata[`LDCR_POS_AUTO_SHORT]),
    .o_q(o_auto_single_short_check_on)
  );

  ldcr_field #(.W(1)) u_volt (
    .i_core_clk(i_core_clk),
    .i_nrst(i_nrst),
    .i_load(load),
    .i_load_val(i_regulator_voltage_select_stored),
    .i_wr(wr_a),
    .i_wr_val(i_reg_wdata[`LDCR_POS_VOLT_SEL]),
    .o_q(o_regulator_voltage_select)
  );

  ldcr_field #(.W(1)) u_exp (
    .i_core_clk(i_core_clk),
    .i_nrst(i_nrst),
    .i_load(load),
    .i_load_val(i_exponential_dimming_on_stored),
    .i_wr(wr_a),
    .i_wr_val(i_reg_wdata[`LDCR_POS_EXP_DIM]),
    .o_q(o_exponential_dimming_on)
  );

  ldcr_field #(.W(4)) u_freq (
    .i_core_clk(i_core_clk),
    .i_nrst(i_nrst),
    .i_load(load),
    .i_load_val(i_pulse_frequency_code_stored),
    .i_wr(wr_b),
    .i_wr_val(i_reg_wdata[`LDCR_POS_FREQ_LSB+:4]),
    .o_q(o_pulse_frequency_code)
  );

  ldcr_field #(.W(2)) u_ratio (
    .i_core_clk(i_core_clk),
    .i_nrst(i_nrst),
    .i_load(load),
    .i_load_val(i_reference_ratio_code_stored),
    .i_wr(wr_b),
    .i_wr_val(i_reg_wdata[`LDCR_POS_RATIO_LSB+:2]),
    .o_q(o_reference_ratio_code)
  );

  // Reserved bits are never stored, so they read back as zero
  always_comb begin
    next_rdata = `LDCR_RST_BYTE;
    case (i_reg_addr)
      `LDCR_OFF_DIAG_LO: next_rdata = o_diag_enable_lo_channels;
      `LDCR_OFF_DIAG_HI: next_rdata[`LDCR_DIAG_HI_W-1:0] = o_diag_enable_hi_channels;
      `LDCR_OFF_MISC_A: begin
        next_rdata[`LDCR_POS_AUTO_SHORT] = o_auto_single_short_check_on;
        next_rdata[`LDCR_POS_VOLT_SEL] = o_regulator_voltage_select;
        next_rdata[`LDCR_POS_EXP_DIM] = o_exponential_dimming_on;
      end
      `LDCR_OFF_MISC_B: begin
        next_rdata[`LDCR_POS_FREQ_LSB+:4] = o_pulse_frequency_code;
        next_rdata[`LDCR_POS_RATIO_LSB+:2] = o_reference_ratio_code;
      end
      default: next_rdata = `LDCR_RST_BYTE;
    endcase
  end

  always_ff @(posedge i_core_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      o_reg_rdata <= `LDCR_RST_BYTE;
      o_reg_rvalid <= 1'b0;
    end else begin
      o_reg_rvalid <= i_reg_rd;
      if (i_reg_rd) begin
        o_reg_rdata <= next_rdata;
      end
    end
  end

  // Frequency table; one cycle behind the code
  always_comb begin
    case (o_pulse_frequency_code)
      4'h0: next_freq = `LDCR_FREQ_0;
      4'h1: next_freq = `LDCR_FREQ_1;
      4'h2: next_freq = `LDCR_FREQ_2;
      4'h3: next_freq = `LDCR_FREQ_3;
      4'h4: next_freq = `LDCR_FREQ_4;
      4'h5: next_freq = `LDCR_FREQ_5;
      4'h6: next_freq = `LDCR_FREQ_6;
      4'h7: next_freq = `LDCR_FREQ_7;
      4'h8: next_freq = `LDCR_FREQ_8;
      4'h9: next_freq = `LDCR_FREQ_9;
      4'hA: next_freq = `LDCR_FREQ_A;
      4'hB: next_freq = `LDCR_FREQ_B;
      4'hC: next_freq = `LDCR_FREQ_C;
      4'hD: next_freq = `LDCR_FREQ_D;
      4'hE: next_freq = `LDCR_FREQ_E;
      4'hF: next_freq = `LDCR_FREQ_F;
      default: next_freq = `LDCR_FREQ_0;
    endcase
  end

  always_ff @(posedge i_core_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      o_pwm_freq_dhz <= `LDCR_FREQ_0;
    end else begin
      o_pwm_freq_dhz <= next_freq;
    end
  end

  always_ff @(posedge i_core_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      o_ref_ratio <= `LDCR_RATIO_BASE;
    end else begin
      o_ref_ratio <= `LDCR_RATIO_BASE << o_reference_ratio_code;
    end
  end

  default clocking cb @(posedge i_core_clk);
  endclocking
  default disable iff (!i_nrst);

  diag_lo_write_a: assert property (
    wr_lo |=>
      o_diag_enable_lo_channels == $past(i_reg_wdata))
    else $error("Low channel diagnostics write not stored");

  diag_hi_resv_a: assert property (
    (i_reg_rd && i_reg_addr == `LDCR_OFF_DIAG_HI) |=>
      o_reg_rvalid && o_reg_rdata == {4'h0, $past(o_diag_enable_hi_channels)})
    else $error("High channel register read wrong");

  // Sampled reset skips the release edge, where the fields still sit in reset
  diag_load_a: assert property (
    (i_nrst && load) |=> {o_diag_enable_hi_channels, o_diag_enable_lo_channels} ==
      $past(i_chan_diag_on_stored) ##1 o_cfg_ready)
    else $error("Diagnostics enables not loaded from stored copy");

  auto_reset_a: assert property (
    (i_nrst && load) |=> !o_auto_single_short_check_on)
    else $error("Auto short check not zero after reset");

  volt_write_a: assert property (
    wr_a |=> o_regulator_voltage_select == $past(i_reg_wdata[6]) &&
      o_auto_single_short_check_on == $past(i_reg_wdata[7]))
    else $error("Voltage select write not stored");

  exp_write_a: assert property (
    wr_a |=> o_exponential_dimming_on == $past(i_reg_wdata[4]))
    else $error("Exponential dimming write not stored");

  misc_a_load_a: assert property (
    (i_nrst && load) |=>
      o_regulator_voltage_select == $past(i_regulator_voltage_select_stored) &&
      o_exponential_dimming_on == $past(i_exponential_dimming_on_stored))
    else $error("Misc A fields not loaded from stored copy");

  freq_top_a: assert property (
    o_pulse_frequency_code == 4'hF |=> o_pwm_freq_dhz == `LDCR_FREQ_F)
    else $error("Highest frequency code decoded wrong");

  freq_low_a: assert property (
    o_pulse_frequency_code == 4'h0 |=> o_pwm_freq_dhz == `LDCR_FREQ_0)
    else $error("Lowest frequency code decoded wrong");

  ratio_dec_a: assert property (
    o_reference_ratio_code == 2'h3 |=> o_ref_ratio == 10'h200)
    else $error("Reference ratio decoded wrong");

  misc_b_load_a: assert property (
    (i_nrst && load) |=>
      o_pulse_frequency_code == $past(i_pulse_frequency_code_stored) &&
      o_reference_ratio_code == $past(i_reference_ratio_code_stored))
    else $error("Misc B fields not loaded from stored copy");

  resv_read_a: assert property (
    (i_reg_rd && i_reg_addr == `LDCR_OFF_MISC_A) ##1 1'b1 |->
      o_reg_rdata[5] == 1'b0 && o_reg_rdata[3:0] == 4'h0)
    else $error("Reserved bits of misc A read nonzero");

  resv_gap_a: assert property (
    (i_reg_rd && i_reg_addr == `LDCR_OFF_MISC_B) |=> o_reg_rdata[3:2] == 2'h0)
    else $error("Reserved gap of misc B read nonzero");

  wr_lo_c: cover property (wr_lo ##1 i_reg_rd && i_reg_addr == `LDCR_OFF_DIAG_LO);
  wr_a_c: cover property (wr_a && i_reg_wdata == 8'hFF);
  freq_max_c: cover property (o_pwm_freq_dhz == `LDCR_FREQ_F);
  ratio_max_c: cover property (o_ref_ratio == 10'h200);

endmodule // ldcr_regs
